// File: fdpr_pkg.sv
// constants, field layouts and carrier types of the divider parameter bank
// assumes a single 40 MHz clock domain and word-wide AHB-Lite access
package fdpr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0] FDPR_IDX_CH1_NUM_LOW = 8'h39;
   localparam logic [7:0] FDPR_IDX_CH1_DEN_MID = 8'h3A;
   localparam logic [7:0] FDPR_IDX_CH1_DEN_LOW = 8'h3B;
   localparam logic [7:0] FDPR_IDX_CH2_DIV_INT_HIGH = 8'h3C;
   localparam logic [7:0] FDPR_IDX_CH2_INT_MID = 8'h3D;
   localparam logic [7:0] FDPR_IDX_CH2_INT_LOW = 8'h3E;
   localparam logic [7:0] FDPR_IDX_CH2_FRAC_NIBBLES = 8'h3F;
   localparam logic [7:0] FDPR_IDX_CH2_NUM_MID = 8'h40;
   localparam logic [7:0] FDPR_IDX_CH2_NUM_LOW = 8'h41;
   localparam logic [7:0] FDPR_IDX_CTRL = 8'h42;
   localparam logic [7:0] FDPR_IDX_STATUS = 8'h43;
   localparam int FDPR_REG_COUNT = 9;
   localparam logic [3:0] FDPR_SLOT_LAST = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int FDPR_OUTDIV_MSB = 6;
   localparam int FDPR_OUTDIV_LSB = 4;
   localparam int FDPR_INT_HIGH_MSB = 1;
   localparam int FDPR_NUM_UPPER_MSB = 3;
   localparam int FDPR_DEN_UPPER_MSB = 7;
   localparam int FDPR_DEN_UPPER_LSB = 4;
   localparam int FDPR_CTRL_HOLD_BIT = 0;
   localparam int FDPR_STAT_CH1_BIT = 9;
   localparam int FDPR_STAT_CH2_BIT = 10;
   localparam int FDPR_STAT_HOLD_BIT = 11;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and bus codes
   localparam logic [7:0] FDPR_PARAM_RESET = 8'h00;
   localparam logic FDPR_CTRL_HOLD_RESET = 1'b0;
   localparam logic [1:0] FDPR_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] FDPR_HSIZE_WORD = 3'h2;
   localparam logic [2:0] FDPR_CH1_MASK_FIRST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      FDPR_BUS_IDLE = 2'b00,
      FDPR_BUS_WRITE = 2'b01,
      FDPR_BUS_READ = 2'b10
   } fdpr_bus_state_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] idx;
      logic [7:0] wdata;
   } fdpr_reg_acc_type;

   typedef struct packed {
      logic [7:0] frac_num_low;
      logic [15:0] frac_den_low;
   } fdpr_ch1_param_type;

   typedef struct packed {
      logic [2:0] output_divider_select;
      logic [17:0] integer_param;
      logic [19:0] frac_numerator;
      logic [3:0] frac_den_upper;
   } fdpr_ch2_param_type;

endpackage

// File: fdpr_ahb_slave.sv
// AHB-Lite front end: turns single word transfers into register strokes
// assumes one master, zero wait states, and hready from the fabric
`timescale 1ns/1ps

module fdpr_ahb_slave (
   input wire logic sys_clk,                     // 40 MHz clock
   input wire logic resetn,                      // async reset, low active
   input wire logic hsel,                        // slave select
   input wire logic [1:0] htrans,                // transfer type
   input wire logic hwrite,                      // write when high
   input wire logic [2:0] hsize,                 // transfer size
   input wire logic [31:0] haddr,                // byte address
   input wire logic hready,                      // bus ready
   input wire logic [31:0] hwdata,               // write data
   output fdpr_pkg::fdpr_reg_acc_type acc,       // register stroke
   output logic hreadyout,                       // slave ready
   output logic hresp                            // response, always okay
);
   import fdpr_pkg::*;

   fdpr_bus_state_type state;
   logic [7:0] wr_idx;
   logic take;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////////
   // address phase
   assign take = hsel && htrans[1] && hready;
   // only aligned words inside the first kilobyte are decoded
   assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) &&
                   (hsize == FDPR_HSIZE_WORD);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= FDPR_BUS_IDLE;
      end else if (take && hwrite) begin
         state <= FDPR_BUS_WRITE;
      end else if (take) begin
         state <= FDPR_BUS_READ;
      end else if (hready) begin
         state <= FDPR_BUS_IDLE;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_idx <= 8'h00;
      end else if (take && hwrite) begin
         // unmapped writes land on an index nobody decodes
         wr_idx <= mapped ? haddr[9:2] : 8'hFF;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strokes: reads in the address phase, writes in the data phase
   always_comb begin
      acc.wr = (state == FDPR_BUS_WRITE);
      acc.rd = take && !hwrite;
      acc.idx = acc.wr ? wr_idx : (mapped ? haddr[9:2] : 8'hFF);
      acc.wdata = hwdata[7:0];
   end

endmodule

// File: fdpr_pow2_div.sv
// power-of-two output divider for the second channel
// assumes src is a level from logic on sys_clk, at most half its rate
`timescale 1ns/1ps

module fdpr_pow2_div (
   input wire logic sys_clk,      // 40 MHz clock
   input wire logic resetn,       // async reset, low active
   input wire logic src,          // undivided channel output
   input wire logic [2:0] sel,    // divide by two to the power sel
   output logic div_out           // divided output
);
   import fdpr_pkg::*;

   logic src_q;
   logic [6:0] edge_cnt;
   logic next_out;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src;
      end
   end

   // each rising edge advances the ripple count; bit n-1 halves n times
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         edge_cnt <= 7'h00;
      end else if (src && !src_q) begin
         edge_cnt <= edge_cnt + 7'h01;
      end
   end

   always_comb begin
      if (sel == 3'h0) begin
         next_out = src;
      end else begin
         next_out = edge_cnt[3'(sel - 3'h1)];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_out <= 1'b0;
      end else begin
         div_out <= next_out;
      end
   end

endmodule

// File: fdpr_regs.sv
// parameter register bank for two fractional divider channels
// assumes an AHB-Lite master on sys_clk; the divider core sits outside
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - bits 6:4 of the channel two select register divide its output by 2^n, 1 to 128.
// - the 18-bit channel two integer parameter is bits 1:0 of 0x3C, then 0x3D, then 0x3E.
// - the 20-bit channel two numerator is bits 3:0 of 0x3F, then 0x40, then 0x41.
// - the channel two denominator upper nibble comes from bits 7:4 of 0x3F.
// - the channel one numerator low byte is a full read-write register.
// - the channel one denominator bytes 15:8 and 7:0 sit at 0x3A and 0x3B.
module fdpr_regs (
   input wire logic sys_clk,                          // 40 MHz clock
   input wire logic resetn,                           // async reset, low active
   input wire logic hsel,                             // AHB slave select
   input wire logic [1:0] htrans,                     // AHB transfer type
   input wire logic hwrite,                           // AHB write
   input wire logic [2:0] hsize,                      // AHB size
   input wire logic [31:0] haddr,                     // AHB byte address
   input wire logic hready,                           // AHB ready in
   input wire logic [31:0] hwdata,                    // AHB write data
   output logic [31:0] hrdata,                        // AHB read data
   output logic hreadyout,                            // AHB ready out
   output logic hresp,                                // AHB response
   input wire logic ch2_synth_in,                     // undivided channel two
   output logic ch2_clk_out,                          // divided channel two
   output fdpr_pkg::fdpr_ch1_param_type ch1_param,    // channel one fields
   output fdpr_pkg::fdpr_ch2_param_type ch2_param,    // channel two fields
   output logic ch1_params_complete,                  // all channel one bytes set
   output logic ch2_params_complete                   // all channel two bytes set
);
   import fdpr_pkg::*;

   fdpr_reg_acc_type acc;
   logic bus_ready;
   logic bus_resp;
   logic [7:0] store [FDPR_REG_COUNT];
   logic [FDPR_REG_COUNT-1:0] slot_hit;
   logic [FDPR_REG_COUNT-1:0] written;
   logic hold;
   logic ctrl_wr;
   logic [7:0] next_byte;
   logic [31:0] next_rdata;
   logic [3:0] rd_slot;
   logic [7:0] rd_idx;
   logic rd_in_bank;
   fdpr_ch1_param_type next_ch1;
   fdpr_ch2_param_type next_ch2;
   logic [2:0] live_div_sel;

   ////////////////////////////////////////////////////////////////////////////
   // bus front end
   fdpr_ahb_slave u_slave (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .hsel(hsel),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .haddr(haddr),
      .hready(hready),
      .hwdata(hwdata),
      .acc(acc),
      .hreadyout(bus_ready),
      .hresp(bus_resp)
   );

   assign hreadyout = bus_ready;
   assign hresp = bus_resp;

   ////////////////////////////////////////////////////////////////////////////
   // byte store, one slot per parameter register
   // values after reset are zero, but software must not count on that
   genvar g;
   generate
      for (g = 0; g < FDPR_REG_COUNT; g = g + 1) begin : g_slot
         assign slot_hit[g] = acc.wr && (acc.idx == FDPR_IDX_CH1_NUM_LOW + 8'(g));

         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               store[g] <= FDPR_PARAM_RESET;
            end else if (slot_hit[g]) begin
               store[g] <= acc.wdata;
            end
         end

         // tracks which bytes the host has supplied since reset
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               written[g] <= 1'b0;
            end else if (slot_hit[g]) begin
               written[g] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // control: hold freezes the live parameters while a set is rewritten
   assign ctrl_wr = acc.wr && (acc.idx == FDPR_IDX_CTRL);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hold <= FDPR_CTRL_HOLD_RESET;
      end else if (ctrl_wr) begin
         hold <= acc.wdata[FDPR_CTRL_HOLD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field assembly from the stored bytes
   always_comb begin
      next_ch1.frac_num_low = store[0];
      next_ch1.frac_den_low = {store[1], store[2]};
      next_ch2.output_divider_select =
         store[3][FDPR_OUTDIV_MSB:FDPR_OUTDIV_LSB];
      next_ch2.integer_param =
         {store[3][FDPR_INT_HIGH_MSB:0], store[4], store[5]};
      next_ch2.frac_numerator =
         {store[6][FDPR_NUM_UPPER_MSB:0], store[7], store[8]};
      next_ch2.frac_den_upper =
         store[6][FDPR_DEN_UPPER_MSB:FDPR_DEN_UPPER_LSB];
   end

   // live copies only move while hold is clear, so a set changes at once
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch1_param <= '0;
      end else if (!hold) begin
         ch1_param <= next_ch1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch2_param <= '0;
      end else if (!hold) begin
         ch2_param <= next_ch2;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch1_params_complete <= 1'b0;
         ch2_params_complete <= 1'b0;
      end else begin
         ch1_params_complete <= &written[2:0];
         ch2_params_complete <= &written[FDPR_REG_COUNT-1:3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output divider on the live select
   assign live_div_sel = ch2_param.output_divider_select;

   fdpr_pow2_div u_div (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .src(ch2_synth_in),
      .sel(live_div_sel),
      .div_out(ch2_clk_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read path, captured in the address phase; decoded from the bus itself
   // so a read in a write's data phase still sees its own address
   assign rd_idx = ((haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) &&
                    (hsize == FDPR_HSIZE_WORD)) ? haddr[9:2] : 8'hFF;
   assign rd_in_bank = (rd_idx >= FDPR_IDX_CH1_NUM_LOW) &&
                       (rd_idx <= FDPR_IDX_CH2_NUM_LOW);
   assign rd_slot = 4'(rd_idx - FDPR_IDX_CH1_NUM_LOW);

   always_comb begin
      next_byte = 8'h00;
      if (rd_in_bank && (rd_slot <= FDPR_SLOT_LAST)) begin
         next_byte = store[rd_slot];
      end
      next_rdata = 32'h0000_0000;
      if (rd_in_bank) begin
         next_rdata = {24'h00_0000, next_byte};
      end else if (rd_idx == FDPR_IDX_CTRL) begin
         next_rdata = {31'h0000_0000, hold};
      end else if (rd_idx == FDPR_IDX_STATUS) begin
         next_rdata = {20'h0_0000, hold, ch2_params_complete,
                       ch1_params_complete, written};
      end
   end

   // a read of the byte being written in the same cycle returns the old byte
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc.rd) begin
         hrdata <= next_rdata;
      end
   end

endmodule

// File: fdpr_src_model.sv
// stand-in for the channel two synthesis stage feeding the output divider
// assumes the same sys_clk domain; quiet and low while reset is held
`timescale 1ns/1ps

module fdpr_src_model (
   input wire logic sys_clk,   // 40 MHz clock
   input wire logic resetn,    // async reset, low active
   output logic src            // undivided channel two signal
);
   logic [1:0] phase;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end

   // period of four cycles keeps within half the sys_clk rate
   assign src = phase[1];
endmodule

// File: fdpr_regs_monitor.sv
// concurrent checks on the ports of the divider parameter bank
// assumes one master, hready looped back from hreadyout, hold cleared by a write
`timescale 1ns/1ps

module fdpr_regs_monitor (
   input wire logic sys_clk,                        // 40 MHz clock
   input wire logic resetn,                         // async reset, low active
   input wire logic hsel,                           // AHB select
   input wire logic [1:0] htrans,                   // AHB transfer type
   input wire logic hwrite,                         // AHB write
   input wire logic [2:0] hsize,                    // AHB size
   input wire logic [31:0] haddr,                   // AHB address
   input wire logic hready,                         // AHB ready in
   input wire logic [31:0] hrdata,                  // AHB read data
   input wire logic hreadyout,                      // AHB ready out
   input wire logic hresp,                          // AHB response
   input wire logic ch2_synth_in,                   // undivided source
   input wire logic ch2_clk_out,                    // divided output
   input wire fdpr_pkg::fdpr_ch1_param_type ch1_param,  // channel one fields
   input wire fdpr_pkg::fdpr_ch2_param_type ch2_param,  // channel two fields
   input wire logic ch1_params_complete,            // channel one complete
   input wire logic ch2_params_complete             // channel two complete
);
   import fdpr_pkg::*;
   logic taken;
   logic wr_taken;
   logic rd_param;
   logic rd_far;
   logic [2:0] sel;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   assign taken = hsel && htrans[1] && hready;
   assign wr_taken = taken && hwrite;
   assign rd_param = taken && !hwrite && hsize == FDPR_HSIZE_WORD && haddr[31:10] == 22'h0
      && haddr[1:0] == 2'h0 && haddr[9:2] >= FDPR_IDX_CH1_NUM_LOW
      && haddr[9:2] <= FDPR_IDX_CH2_NUM_LOW;
   assign rd_far = taken && !hwrite && haddr[31:10] != 22'h0;
   assign sel = ch2_param.output_divider_select;

   ////////////////////////////////////////////////////////////////////////////
   property p_ready; hreadyout == 1'b1; endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_byte; rd_param |=> hrdata[31:8] == 24'h0; endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
   property p_rd_far; rd_far |=> hrdata == 32'h0; endproperty
   a_rd_far: assert property (p_rd_far) else $error("unmapped read not zero");
   // live fields move only as a consequence of a recent write
   property p_ch1_cause;
      $changed(ch1_param) |-> $past(wr_taken, 2) || $past(wr_taken, 3) || $past(wr_taken, 4);
   endproperty
   a_ch1_cause: assert property (p_ch1_cause) else $error("ch1 fields moved");
   property p_ch2_cause;
      $changed(ch2_param) |-> $past(wr_taken, 2) || $past(wr_taken, 3) || $past(wr_taken, 4);
   endproperty
   a_ch2_cause: assert property (p_ch2_cause) else $error("ch2 fields moved");
   property p_div_one;
      sel == 3'h0 && $past(sel) == 3'h0 && $past(sel, 2) == 3'h0
         |-> ch2_clk_out == $past(ch2_synth_in);
   endproperty
   a_div_one: assert property (p_div_one) else $error("divide by one wrong");
   // with a settled nonzero select the output moves only after a source rise
   property p_div_n;
      sel != 3'h0 && $stable(sel) && $past(sel) == $past(sel, 2) && $changed(ch2_clk_out)
         |-> ($past(ch2_synth_in, 2) && !$past(ch2_synth_in, 3))
         || ($past(ch2_synth_in, 3) && !$past(ch2_synth_in, 4))
         || ($past(ch2_synth_in, 4) && !$past(ch2_synth_in, 5));
   endproperty
   a_div_n: assert property (p_div_n) else $error("divided output moved alone");
   property p_cmpl1; !$fell(ch1_params_complete); endproperty
   a_cmpl1: assert property (p_cmpl1) else $error("ch1 complete dropped");
   property p_cmpl2; !$fell(ch2_params_complete); endproperty
   a_cmpl2: assert property (p_cmpl2) else $error("ch2 complete dropped");
endmodule

// File: fdpr_regs_test.sv
// self-checking bench for the divider parameter bank over AHB-Lite
// assumes the source model and the monitor compiled beforehand
`timescale 1ns/1ps

module fdpr_regs_test;
   import fdpr_pkg::*;
   logic sys_clk;
   logic resetn;
   logic hsel;
   logic hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic src;
   logic ch2_clk_out;
   logic c1;
   logic c2;
   fdpr_ch1_param_type ch1_param;
   fdpr_ch2_param_type ch2_param;
   logic [7:0] vals [9] = '{8'hA5, 8'h5C, 8'hC3, 8'hFE, 8'h12, 8'h34, 8'h9E, 8'h56, 8'h78};
   logic [7:0] d;
   logic [21:0] far = 22'h0;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   int p;

   fdpr_src_model u_src (.sys_clk(sys_clk), .resetn(resetn), .src(src));
   fdpr_regs DUT (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch2_synth_in(src),
      .ch2_clk_out(ch2_clk_out), .ch1_param(ch1_param), .ch2_param(ch2_param),
      .ch1_params_complete(c1), .ch2_params_complete(c2));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one single word transfer; waits on hready, never on a fixed count
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= FDPR_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {far, idx, 2'b00};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // first rise after a select change may be short, so skip it
   task automatic measure;
      @(posedge ch2_clk_out);
      @(posedge ch2_clk_out);
      p = cyc;
      @(posedge ch2_clk_out);
      p = cyc - p;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = FDPR_HSIZE_WORD;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         xfer(1'b0, FDPR_IDX_CH1_NUM_LOW + 8'(i), 32'h0);
         check(rd, 48'h0);
      end
      // junk above bit 7 must be dropped
      for (int i = 0; i < 9; i++) begin
         xfer(1'b1, FDPR_IDX_CH1_NUM_LOW + 8'(i), {24'hFFFFFF, vals[i]});
         if (i == 2) begin
            repeat (3) @(posedge sys_clk);
            check({c1, c2}, 48'h2);
         end
      end
      repeat (3) @(posedge sys_clk);
      check({c1, c2}, 48'h3);
      for (int i = 0; i < 9; i++) begin
         xfer(1'b0, FDPR_IDX_CH1_NUM_LOW + 8'(i), 32'h0);
         check(rd, {40'h0, vals[i]});
      end
      check(ch1_param.frac_num_low, 48'hA5);
      check(ch1_param.frac_den_low, 48'h5CC3);
      check(ch2_param.output_divider_select, 48'h7);
      check(ch2_param.integer_param, 48'h21234);
      check(ch2_param.frac_numerator, 48'hE5678);
      check(ch2_param.frac_den_upper, 48'h9);
      // hold freezes the live fields while the store still takes writes
      xfer(1'b1, FDPR_IDX_CTRL, 32'h0000_0001);
      xfer(1'b1, FDPR_IDX_CH1_NUM_LOW, 32'h0000_003C);
      repeat (3) @(posedge sys_clk);
      check(ch1_param.frac_num_low, 48'hA5);
      xfer(1'b0, FDPR_IDX_CTRL, 32'h0);
      check(rd, 48'h1);
      xfer(1'b0, FDPR_IDX_STATUS, 32'h0);
      check(rd, 48'hFFF);
      // address bits above the first kilobyte must not alias into the bank
      far = 22'h1;
      xfer(1'b0, FDPR_IDX_CH1_NUM_LOW, 32'h0);
      far = 22'h0;
      check(rd, 48'h0);
      xfer(1'b1, FDPR_IDX_CTRL, 32'h0);
      repeat (3) @(posedge sys_clk);
      check(ch1_param.frac_num_low, 48'h3C);
      xfer(1'b0, FDPR_IDX_CH1_NUM_LOW, 32'h0);
      check(rd, 48'h3C);
      xfer(1'b1, 8'h50, 32'h000000AA);
      xfer(1'b0, 8'h50, 32'h0);
      check(rd, 48'h0);
      // every select code, with unused and reserved bits stirred
      for (int n = 0; n < 8; n++) begin
         d = {n[0], 3'(n), n[1:0], 2'b10};
         xfer(1'b1, FDPR_IDX_CH2_DIV_INT_HIGH, {24'h0, d});
         xfer(1'b0, FDPR_IDX_CH2_DIV_INT_HIGH, 32'h0);
         check(rd, {40'h0, d});
         check(ch2_param.integer_param, 48'h21234);
         measure();
         check(p, 48'(4 << n));
      end
      finish_test();
   end

   initial begin
      #500000;
      failures = failures + 1;
      finish_test();
   end
endmodule

bind fdpr_regs fdpr_regs_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch2_synth_in(ch2_synth_in),
   .ch2_clk_out(ch2_clk_out), .ch1_param(ch1_param), .ch2_param(ch2_param),
   .ch1_params_complete(ch1_params_complete), .ch2_params_complete(ch2_params_complete));
